// [logic/fkey_regs.vh]
// Notes on behaviour
// - three keys each hold a function code 0..72, and a press on a key acts by that key's code.
// - code 1 toggles the difference view on a short press and swaps remote/auto on a 2 s hold; code 0 does nothing.
// - code 2 toggles standby/run, 3 releases alarm latches, 10 starts/stops tuning, 30..32 drive the totalizer, 60..62 jump to parameters.
// - codes 20..27 start or stop the timer of alarm channels 1..8, one channel per code.
// - codes 41..47 copy stored set values 1..7 into the local set value.
// - codes 50..57 select palette 0..7.
// - code 70 toggles ramp/soak run/off, 71 toggles run/hold, 72 advances the pattern number by one, wrapping to pmin once it reaches pmax.
// - with code 1, each short press on the operating screen alternates difference view and normal view.
// - the view toggle works in both auto and remote operation.
// - with code 1, a 2 s hold on the operating screen swaps remote and auto.
// - the difference shows local minus remote; editing it sets local to remote plus the difference.
// - going from remote to auto, the local set value takes the remote value so the target does not jump.
// - in remote operation the control target is the remote set value.
// - standby/run switches only after a 1 s hold.
`ifndef FKEY_REGS_VH
`define FKEY_REGS_VH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define FK_OFS_KEY1      12'h000
`define FK_OFS_KEY2      12'h004
`define FK_OFS_KEY3      12'h008
`define FK_OFS_CTRL      12'h00C
`define FK_OFS_STATUS    12'h010
`define FK_OFS_LSV       12'h014
`define FK_OFS_RSV       12'h018
`define FK_OFS_DIFF      12'h01C
`define FK_OFS_TARGET    12'h020
`define FK_OFS_SVTAB     12'h040
`define FK_OFS_JUMP      12'h060

// ctrl field positions
`define FK_CTRL_OPSCR    0
`define FK_CTRL_RSON     1
`define FK_CTRL_TPL_LO   8
`define FK_CTRL_TPL_HI   15
`define FK_CTRL_PMIN_LO  16
`define FK_CTRL_PMIN_HI  19
`define FK_CTRL_PMAX_LO  20
`define FK_CTRL_PMAX_HI  23

// status field positions
`define FK_ST_DIFFVIEW   0
`define FK_ST_REMOTE     1
`define FK_ST_STANDBY    2
`define FK_ST_TUNING     3
`define FK_ST_TOTRUN     4
`define FK_ST_TOTLATCH   5
`define FK_ST_RSRUN      6
`define FK_ST_RSHOLD     7
`define FK_ST_PAL_LO     8
`define FK_ST_PAL_HI     10
`define FK_ST_PAT_LO     12
`define FK_ST_PAT_HI     15
`define FK_ST_TMR_LO     16
`define FK_ST_TMR_HI     23

// reset values
`define FK_CODE_RST      7'h00
`define FK_CTRL_RST      32'h00F00001

// codes
`define FK_C_NONE        7'h00
`define FK_C_DIFF        7'h01
`define FK_C_STBY        7'h02
`define FK_C_ALATCH      7'h03
`define FK_C_TUNE        7'h0A
`define FK_C_TMR0        7'h14
`define FK_C_TMR7        7'h1B
`define FK_C_TOTHOLD     7'h1E
`define FK_C_TOTLATCH    7'h1F
`define FK_C_TOTRST      7'h20
`define FK_C_SV1         7'h29
`define FK_C_SV7         7'h2F
`define FK_C_PAL0        7'h32
`define FK_C_PAL7        7'h39
`define FK_C_JMP1        7'h3C
`define FK_C_JMP3        7'h3E
`define FK_C_RSOFF       7'h46
`define FK_C_RSHOLD      7'h47
`define FK_C_RSPAT       7'h48

// timing
`define FK_CLK_HZ        40000000
`define FK_HOLD_LONG_MS  2000
`define FK_HOLD_SHORT_MS 1000
`define FK_LONG_CYC      ((`FK_CLK_HZ / 1000) * `FK_HOLD_LONG_MS)
`define FK_SHORT_CYC     ((`FK_CLK_HZ / 1000) * `FK_HOLD_SHORT_MS)

`endif

// [logic/key_timer.v]
`timescale 1ns/10ps
`include "fkey_regs.vh"
`default_nettype none

module key_timer #(
  parameter integer LONG_CYC  = `FK_LONG_CYC,
  parameter integer SHORT_CYC = `FK_SHORT_CYC
) (
  // clock and reset
  input  wire mclk,
  input  wire rst,
  // key level
  input  wire key_in,
  // events
  output reg  short_press,
  output reg  hold_1s,
  output reg  hold_2s
);

  reg [26:0] cnt_r;
  reg        key_d_r;

  // ----------------------------------------------------------------
  // hold timing
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    if (rst) begin
      cnt_r       <= 27'h0000000;
      key_d_r     <= 1'b0;
      short_press <= 1'b0;
      hold_1s     <= 1'b0;
      hold_2s     <= 1'b0;
    end else begin
      key_d_r     <= key_in;
      short_press <= 1'b0;
      hold_1s     <= 1'b0;
      hold_2s     <= 1'b0;
      if (key_in) begin
        if (cnt_r != 27'h7FFFFFF)
          cnt_r <= cnt_r + 27'h0000001;
        if (cnt_r == SHORT_CYC[26:0] - 27'h0000001)
          hold_1s <= 1'b1;
        if (cnt_r == LONG_CYC[26:0] - 27'h0000001)
          hold_2s <= 1'b1;
      end else begin
        cnt_r <= 27'h0000000;
        if (key_d_r && cnt_r < SHORT_CYC[26:0])
          short_press <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// [logic/function_key_dispatcher.v]
// Our own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`include "fkey_regs.vh"
`default_nettype none

module function_key_dispatcher #(
  parameter integer LONG_CYC  = `FK_LONG_CYC,
  parameter integer SHORT_CYC = `FK_SHORT_CYC,
  parameter integer SVW       = 16
) (
  // clock and reset
  input  wire        mclk,
  input  wire        rst,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [11:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  // front-panel keys
  input  wire        user_key_one,
  input  wire        user_key_two,
  input  wire        user_key_three,
  // remote set value from outside
  input  wire [15:0] remote_set_value,
  // action pulses
  output reg         alarm_latch_release,
  output reg  [2:0]  param_jump,
  output reg         totalizer_reset,
  // control target
  output reg  [15:0] control_target
);

  // ----------------------------------------------------------------
  // configuration and state
  // ----------------------------------------------------------------
  reg  [6:0]     code_r [0:2];
  reg  [31:0]    ctrl_r;
  reg  [SVW-1:0] lsv_r;
  reg  [SVW-1:0] svtab_r [0:6];
  reg            diffview_r;
  reg            remote_r;
  reg            standby_r;
  reg            tuning_r;
  reg            totrun_r;
  reg            totlatch_r;
  reg            rsrun_r;
  reg            rshold_r;
  reg  [2:0]     palette_r;
  reg  [3:0]     pattern_r;
  reg  [7:0]     timer_r;
  reg  [2:0]     jump_last_r;

  // bus address phase capture
  reg            wr_r;
  reg  [11:0]    addr_r;

  wire [2:0]     key_lvl;
  wire [2:0]     ev_short;
  wire [2:0]     ev_1s;
  wire [2:0]     ev_2s;

  assign key_lvl = {user_key_three, user_key_two, user_key_one};
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ----------------------------------------------------------------
  // per-key hold timers
  // ----------------------------------------------------------------
  // each key timed on its own; same-cycle events from two keys go to the lower-numbered key alone
  genvar gk;
  generate
    for (gk = 0; gk < 3; gk = gk + 1) begin : g_key
      key_timer #(
        .LONG_CYC  (LONG_CYC),
        .SHORT_CYC (SHORT_CYC)
      ) u_tmr (
        .mclk        (mclk),
        .rst         (rst),
        .key_in      (key_lvl[gk]),
        .short_press (ev_short[gk]),
        .hold_1s     (ev_1s[gk]),
        .hold_2s     (ev_2s[gk])
      );
    end
  endgenerate

  wire       op_screen = ctrl_r[`FK_CTRL_OPSCR];
  wire [3:0] pmin      = ctrl_r[`FK_CTRL_PMIN_HI:`FK_CTRL_PMIN_LO];
  wire [3:0] pmax      = ctrl_r[`FK_CTRL_PMAX_HI:`FK_CTRL_PMAX_LO];

  // ----------------------------------------------------------------
  // action decode, key 1 has priority in one cycle
  // ----------------------------------------------------------------
  reg       a_view;
  reg       a_rmt;
  reg       a_stby;
  reg       a_alm;
  reg       a_tune;
  reg       a_tot0;
  reg       a_tot1;
  reg       a_totr;
  reg       a_sv;
  reg       a_pal;
  reg       a_jmp;
  reg       a_rs0;
  reg       a_rs1;
  reg       a_pat;
  reg       a_tmr;
  reg [6:0] a_code;
  integer   k;

  always @* begin
    a_view = 1'b0;
    a_rmt  = 1'b0;
    a_stby = 1'b0;
    a_alm  = 1'b0;
    a_tune = 1'b0;
    a_tot0 = 1'b0;
    a_tot1 = 1'b0;
    a_totr = 1'b0;
    a_sv   = 1'b0;
    a_pal  = 1'b0;
    a_jmp  = 1'b0;
    a_rs0  = 1'b0;
    a_rs1  = 1'b0;
    a_pat  = 1'b0;
    a_tmr  = 1'b0;
    a_code = `FK_C_NONE;
    // key 1 visited last, so it wins a same-cycle tie
    for (k = 2; k >= 0; k = k - 1) begin
      if (ev_short[k] || ev_1s[k] || ev_2s[k]) begin
        a_view = 1'b0;
        a_rmt  = 1'b0;
        a_stby = 1'b0;
        a_alm  = 1'b0;
        a_tune = 1'b0;
        a_tot0 = 1'b0;
        a_tot1 = 1'b0;
        a_totr = 1'b0;
        a_sv   = 1'b0;
        a_pal  = 1'b0;
        a_jmp  = 1'b0;
        a_rs0  = 1'b0;
        a_rs1  = 1'b0;
        a_pat  = 1'b0;
        a_tmr  = 1'b0;
        a_code = code_r[k];
        case (code_r[k])
          `FK_C_DIFF: begin
            a_view = ev_short[k] && op_screen;
            a_rmt  = ev_2s[k] && op_screen;
          end
          `FK_C_STBY:     a_stby = ev_1s[k];
          `FK_C_ALATCH:   a_alm  = ev_short[k];
          `FK_C_TUNE:     a_tune = ev_short[k];
          `FK_C_TOTHOLD:  a_tot0 = ev_short[k];
          `FK_C_TOTLATCH: a_tot1 = ev_short[k];
          `FK_C_TOTRST:   a_totr = ev_1s[k];
          `FK_C_RSOFF:    a_rs0  = ev_short[k];
          `FK_C_RSHOLD:   a_rs1  = ev_short[k];
          `FK_C_RSPAT:    a_pat  = ev_short[k];
          default: begin
            if (code_r[k] >= `FK_C_TMR0 && code_r[k] <= `FK_C_TMR7)
              a_tmr = ev_short[k];
            else if (code_r[k] >= `FK_C_SV1 && code_r[k] <= `FK_C_SV7)
              a_sv = ev_1s[k] && op_screen;
            else if (code_r[k] >= `FK_C_PAL0 && code_r[k] <= `FK_C_PAL7)
              a_pal = ev_1s[k] && op_screen;
            else if (code_r[k] >= `FK_C_JMP1 && code_r[k] <= `FK_C_JMP3)
              a_jmp = ev_short[k];
            // other codes do nothing
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // action operands
  // ----------------------------------------------------------------
  wire [6:0] tmr_idx = a_code - `FK_C_TMR0;
  wire [6:0] sv_idx  = a_code - `FK_C_SV1;
  wire [6:0] pal_idx = a_code - `FK_C_PAL0;
  wire [6:0] jmp_idx = a_code - `FK_C_JMP1;
  wire [3:0] pat_inc = (pattern_r >= pmax) ? pmin : pattern_r + 4'h1;

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  wire take = hsel && hready && htrans[1];
  wire [SVW-1:0] diff_val = lsv_r - remote_set_value[SVW-1:0];
  reg  [31:0]    status_w;

  always @* begin
    status_w                              = 32'h00000000;
    status_w[`FK_ST_DIFFVIEW]             = diffview_r;
    status_w[`FK_ST_REMOTE]               = remote_r;
    status_w[`FK_ST_STANDBY]              = standby_r;
    status_w[`FK_ST_TUNING]               = tuning_r;
    status_w[`FK_ST_TOTRUN]               = totrun_r;
    status_w[`FK_ST_TOTLATCH]             = totlatch_r;
    status_w[`FK_ST_RSRUN]                = rsrun_r;
    status_w[`FK_ST_RSHOLD]               = rshold_r;
    status_w[`FK_ST_PAL_HI:`FK_ST_PAL_LO] = palette_r;
    status_w[`FK_ST_PAT_HI:`FK_ST_PAT_LO] = pattern_r;
    status_w[`FK_ST_TMR_HI:`FK_ST_TMR_LO] = timer_r;
  end

  // ----------------------------------------------------------------
  // address phase capture
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    if (rst) begin
      wr_r   <= 1'b0;
      addr_r <= 12'h000;
    end else begin
      wr_r   <= take && hwrite;
      addr_r <= haddr;
    end
  end

  // read data taken in the address phase, stands in the data phase
  always @(posedge mclk) begin
    if (rst) begin
      hrdata <= 32'h00000000;
    end else if (take && !hwrite) begin
      case ({haddr[11:2], 2'b00})
        `FK_OFS_KEY1:   hrdata <= {25'h0000000, code_r[0]};
        `FK_OFS_KEY2:   hrdata <= {25'h0000000, code_r[1]};
        `FK_OFS_KEY3:   hrdata <= {25'h0000000, code_r[2]};
        `FK_OFS_CTRL:   hrdata <= ctrl_r;
        `FK_OFS_STATUS: hrdata <= status_w;
        `FK_OFS_LSV:    hrdata <= {{(32-SVW){1'b0}}, lsv_r};
        `FK_OFS_RSV:    hrdata <= {16'h0000, remote_set_value};
        `FK_OFS_DIFF:   hrdata <= {{(32-SVW){diff_val[SVW-1]}}, diff_val};
        `FK_OFS_TARGET: hrdata <= {16'h0000, control_target};
        `FK_OFS_JUMP:   hrdata <= {29'h00000000, jump_last_r};
        default: begin
          if (haddr[11:5] == 7'h02 && haddr[4:2] != 3'h7)
            hrdata <= {{(32-SVW){1'b0}}, svtab_r[haddr[4:2]]};
          else
            hrdata <= 32'h00000000;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // control state
  // ----------------------------------------------------------------
  integer i;
  always @(posedge mclk) begin
    if (rst) begin
      for (i = 0; i < 3; i = i + 1)
        code_r[i] <= `FK_CODE_RST;
      for (i = 0; i < 7; i = i + 1)
        svtab_r[i] <= {SVW{1'b0}};
      ctrl_r              <= `FK_CTRL_RST;
      lsv_r               <= {SVW{1'b0}};
      diffview_r          <= 1'b0;
      remote_r            <= 1'b0;
      standby_r           <= 1'b0;
      tuning_r            <= 1'b0;
      totrun_r            <= 1'b0;
      totlatch_r          <= 1'b0;
      rsrun_r             <= 1'b0;
      rshold_r            <= 1'b0;
      palette_r           <= 3'h0;
      pattern_r           <= 4'h0;
      timer_r             <= 8'h00;
      jump_last_r         <= 3'h0;
      alarm_latch_release <= 1'b0;
      param_jump          <= 3'h0;
      totalizer_reset     <= 1'b0;
      control_target      <= 16'h0000;
    end else begin
      alarm_latch_release <= a_alm;
      totalizer_reset     <= a_totr;
      param_jump          <= 3'h0;
      if (a_jmp) begin
        param_jump[jmp_idx[1:0]] <= 1'b1;
        jump_last_r <= jmp_idx[2:0] + 3'h1;
      end
      control_target <= remote_r ? remote_set_value : lsv_r;
      if (a_view)
        diffview_r <= !diffview_r;
      if (a_rmt) begin
        remote_r <= !remote_r;
        if (remote_r && ctrl_r[`FK_CTRL_RSON])
          lsv_r <= remote_set_value[SVW-1:0];
      end
      if (a_stby)
        standby_r <= !standby_r;
      if (a_tune)
        tuning_r <= !tuning_r;
      if (a_tot0) begin
        totrun_r <= !totrun_r;
        totlatch_r <= 1'b0;
      end
      if (a_tot1) begin
        totrun_r <= totlatch_r;
        totlatch_r <= !totlatch_r;
      end
      if (a_tmr)
        timer_r[tmr_idx[2:0]] <= !timer_r[tmr_idx[2:0]];
      if (a_sv)
        lsv_r <= svtab_r[sv_idx[2:0]];
      if (a_pal)
        palette_r <= pal_idx[2:0];
      if (a_rs0) begin
        rsrun_r <= !rsrun_r;
        rshold_r <= 1'b0;
      end
      if (a_rs1) begin
        rsrun_r <= rshold_r;
        rshold_r <= !rshold_r;
      end
      if (a_pat)
        pattern_r <= pat_inc;
      // a bus write lands after the key actions and wins
      if (wr_r) begin
        case ({addr_r[11:2], 2'b00})
          `FK_OFS_KEY1: code_r[0] <= hwdata[6:0];
          `FK_OFS_KEY2: code_r[1] <= hwdata[6:0];
          `FK_OFS_KEY3: code_r[2] <= hwdata[6:0];
          `FK_OFS_CTRL: ctrl_r <= hwdata;
          `FK_OFS_LSV:  lsv_r <= hwdata[SVW-1:0];
          `FK_OFS_DIFF:
            lsv_r <= remote_set_value[SVW-1:0] + hwdata[SVW-1:0];
          default: begin
            if (addr_r[11:5] == 7'h02 && addr_r[4:2] != 3'h7)
              svtab_r[addr_r[4:2]] <= hwdata[SVW-1:0];
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// [sim/fkd_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
module fkd_asserts #(
  parameter integer LONG_CYC  = 40,
  parameter integer SHORT_CYC = 20
) (
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  // bus answer
  input wire logic        hreadyout,
  input wire logic        hresp,
  // keys
  input wire logic        user_key_one,
  input wire logic        user_key_two,
  input wire logic        user_key_three,
  // actions
  input wire logic        alarm_latch_release,
  input wire logic [2:0]  param_jump,
  input wire logic        totalizer_reset,
  input wire logic [15:0] control_target
);
  // ----------------------------------------
  // key timing helpers
  // ----------------------------------------
  wire       any_key = user_key_one | user_key_two | user_key_three;
  logic [3:0] since_r;
  logic [7:0] held_r;
  always @(posedge mclk) begin
    if (rst) begin
      since_r <= 4'hF;
      held_r  <= 8'h00;
    end else begin
      since_r <= any_key ? 4'h0 : (since_r == 4'hF ? 4'hF : since_r + 4'h1);
      held_r  <= !any_key ? 8'h00 : (held_r == 8'hFF ? 8'hFF : held_r + 8'h01);
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  a_zero_wait: assert property (hreadyout == 1'b1)
    else $error("bus ready dropped");
  a_alarm_single: assert property (
    alarm_latch_release |=> !alarm_latch_release)
    else $error("alarm release pulse too long");
  a_jump_onehot: assert property (
    (param_jump != 3'b000) |-> $onehot(param_jump) ##1 (param_jump == 3'b000))
    else $error("jump pulse not one-hot single cycle");
  a_one_action: assert property (
    $onehot0({alarm_latch_release, |param_jump, totalizer_reset}))
    else $error("two actions at once");
  a_short_origin: assert property (
    (alarm_latch_release || param_jump != 3'b000) |-> since_r >= 4'h1 && since_r <= 4'h5)
    else $error("short action without a release");
  a_tot_hold: assert property (
    totalizer_reset |-> any_key && held_r >= SHORT_CYC - 3 && held_r <= SHORT_CYC + 3)
    else $error("totalizer reset not at hold threshold");
  a_reset_quiet: assert property (disable iff (1'b0)
    rst |=> !alarm_latch_release && param_jump == 3'b000 && !totalizer_reset
            && control_target == 16'h0000)
    else $error("outputs active after reset");
endmodule
`default_nettype wire

// [sim/front_panel_keys.sv]
`timescale 1ns/10ps
`default_nettype none
module front_panel_keys (
  // clock
  input wire logic       mclk,
  // key levels
  output var logic [2:0] key_lv
);
  initial key_lv = 3'b000;
  // holds one key for cyc edges, others idle low
  task automatic press(input int k, input int cyc);
    @(posedge mclk);
    key_lv[k] <= 1'b1;
    repeat (cyc) @(posedge mclk);
    key_lv[k] <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [sim/function_key_dispatcher_tb.sv]
`timescale 1ns/10ps
`include "fkey_regs.vh"
`default_nettype none
module function_key_dispatcher_tb;
  localparam integer LC = 40;
  localparam integer SC = 20;
  localparam integer S1 = SC + 4;
  localparam integer S2 = LC + 4;
  localparam logic [31:0] AL = 32'hFFFFFFFF;
  logic        mclk;
  logic        rst;
  logic        hsel;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [2:0]  key_lv;
  logic [15:0] rsv;
  logic        alr;
  logic [2:0]  pj;
  logic        tot;
  logic [15:0] target;
  int          n_mismatch;
  int          checked;
  int          n_alr;
  int          n_tot;
  int          n_jmp [3];

  function_key_dispatcher #(.LONG_CYC(LC), .SHORT_CYC(SC)) dut_u (
    .mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .user_key_one(key_lv[0]), .user_key_two(key_lv[1]), .user_key_three(key_lv[2]),
    .remote_set_value(rsv), .alarm_latch_release(alr), .param_jump(pj),
    .totalizer_reset(tot), .control_target(target));
  front_panel_keys keys_u (.mclk(mclk), .key_lv(key_lv));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (alr === 1'b1) n_alr++;
    if (tot === 1'b1) n_tot++;
    for (int i = 0; i < 3; i++) if (pj[i] === 1'b1) n_jmp[i]++;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= w;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    q = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(n, q & m, e);
  endtask
  // code 1 only ever goes in with template bits left at zero
  task automatic act(input int k, input logic [31:0] c, input int cyc);
    wr(`FK_OFS_KEY1 + 12'(4 * k), c);
    keys_u.press(k, cyc);
    repeat (8) @(posedge mclk);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    rdc("ctrl", `FK_OFS_CTRL, AL, `FK_CTRL_RST);
    rdc("key3", `FK_OFS_KEY3, AL, 32'h0);
    rdc("status", `FK_OFS_STATUS, AL, 32'h0);
    wr(12'h100, AL);
    rdc("unmapped", 12'h100, AL, 32'h0);
  endtask
  task automatic t_pulses;
    act(2, `FK_C_ALATCH, 3);
    chk("alarm", n_alr, 1);
    for (int i = 0; i < 3; i++) begin
      act(1, `FK_C_JMP1 + i, 3);
      chk("jump", n_jmp[i], 1);
      rdc("jumpreg", `FK_OFS_JUMP, 32'h7, i + 1);
    end
    act(0, `FK_C_TOTRST, 3);
    act(0, `FK_C_TOTRST, S1);
    chk("totreset", n_tot, 1);
  endtask
  task automatic t_none;
    logic [31:0] s0;
    int c [4] = '{0, 4, 73, 99};
    bus(1'b0, `FK_OFS_STATUS, 32'h0, s0);
    foreach (c[i]) begin
      act(0, c[i], 3);
      act(0, c[i], S2);
    end
    rdc("status", `FK_OFS_STATUS, AL, s0);
    chk("pulses", n_alr + n_tot + n_jmp[0] + n_jmp[1] + n_jmp[2], 5);
  endtask
  task automatic t_diff;
    act(0, `FK_C_DIFF, 3);
    rdc("view", `FK_OFS_STATUS, 32'h3, 32'h1);
    act(0, `FK_C_DIFF, 3);
    rdc("view", `FK_OFS_STATUS, 32'h3, 32'h0);
    rsv <= 16'h1234;
    act(0, `FK_C_DIFF, S2);
    rdc("remote", `FK_OFS_STATUS, 32'h3, 32'h2);
    chk("target", target, 32'h1234);
    act(0, `FK_C_DIFF, 3);
    rdc("view", `FK_OFS_STATUS, 32'h3, 32'h3);
    wr(`FK_OFS_DIFF, 32'h0005);
    rdc("lsv", `FK_OFS_LSV, 32'hFFFF, 32'h1239);
    rdc("diff", `FK_OFS_DIFF, 32'hFFFF, 32'h0005);
    wr(`FK_OFS_CTRL, 32'h00F00003);
    act(0, `FK_C_DIFF, S2);
    rdc("lsv", `FK_OFS_LSV, 32'hFFFF, 32'h1234);
    chk("target", target, 32'h1234);
  endtask
  task automatic t_modes;
    act(0, `FK_C_STBY, 3);
    rdc("standby", `FK_OFS_STATUS, 32'h4, 32'h0);
    act(0, `FK_C_STBY, S1);
    rdc("standby", `FK_OFS_STATUS, 32'h4, 32'h4);
    act(0, `FK_C_TUNE, 3);
    rdc("tuning", `FK_OFS_STATUS, 32'h8, 32'h8);
    act(0, `FK_C_TOTHOLD, 3);
    rdc("totrun", `FK_OFS_STATUS, 32'h10, 32'h10);
    act(0, `FK_C_TOTLATCH, 3);
    for (int i = 0; i < 8; i++) begin
      act(0, `FK_C_TMR0 + i, 3);
      rdc("timers", `FK_OFS_STATUS, 32'hFF0000, ((2 << i) - 1) << 16);
    end
    for (int i = 7; i >= 0; i--) begin
      act(0, `FK_C_PAL0 + i, S1);
      rdc("palette", `FK_OFS_STATUS, 32'h700, i << 8);
    end
  endtask
  task automatic t_svcopy;
    wr(`FK_OFS_SVTAB + 12'h008, 32'h0ABC);
    act(0, `FK_C_SV1 + 2, S1);
    rdc("lsv", `FK_OFS_LSV, 32'hFFFF, 32'h0ABC);
    wr(`FK_OFS_SVTAB + 12'h018, 32'h0777);
    act(0, `FK_C_SV7, S1);
    rdc("lsv", `FK_OFS_LSV, 32'hFFFF, 32'h0777);
    chk("target", target, 32'h0777);
  endtask
  task automatic t_ramp;
    act(0, `FK_C_RSOFF, 3);
    rdc("rsrun", `FK_OFS_STATUS, 32'h40, 32'h40);
    act(0, `FK_C_RSHOLD, 3);
    rdc("rshold", `FK_OFS_STATUS, 32'h80, 32'h80);
    wr(`FK_OFS_CTRL, 32'h00100001);
    act(0, `FK_C_RSPAT, 3);
    rdc("pattern", `FK_OFS_STATUS, 32'hF000, 32'h1000);
    act(0, `FK_C_RSPAT, 3);
    rdc("pattern", `FK_OFS_STATUS, 32'hF000, 32'h0000);
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    hsel = 1'b1;
    haddr = 12'h000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    rsv = 16'h0000;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    t_reset;
    t_pulses;
    t_none;
    t_diff;
    t_modes;
    t_svcopy;
    t_ramp;
    finish_test;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    finish_test;
  end
endmodule
bind function_key_dispatcher fkd_asserts #(.LONG_CYC(LONG_CYC), .SHORT_CYC(SHORT_CYC)) chk_u (
  .mclk(mclk), .rst(rst), .hreadyout(hreadyout), .hresp(hresp),
  .user_key_one(user_key_one), .user_key_two(user_key_two),
  .user_key_three(user_key_three), .alarm_latch_release(alarm_latch_release),
  .param_jump(param_jump), .totalizer_reset(totalizer_reset),
  .control_target(control_target));
`default_nettype wire
